// ===== shared/dpmc_pkg.sv
// Constants and types for the push-pull driver protection and mode control.
// Assumes a single 100 MHz clock and comparator results arriving as pins.
`default_nettype none
package dpmc_pkg;
  localparam int CLK_PERIOD_NS = 10;
  // Overvoltage stop delay, least time, rounded up.
  localparam int OVP_DELAY_NS = 550;
  localparam int OVP_DELAY_CYC = (OVP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Hiccup off-time after a limit trip.
  localparam int HICCUP_NS = 100;
  localparam int HICCUP_CYC = (HICCUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Hard-short response, longest time, rounded down.
  localparam int HARD_RESP_NS = 65;
  localparam int HARD_RESP_CYC = HARD_RESP_NS / CLK_PERIOD_NS;
  // Hard-short persistence before the soft-start capacitor is dumped.
  localparam int HARD_PERSIST_US = 200;
  localparam int HARD_PERSIST_CYC = HARD_PERSIST_US * 1000 / CLK_PERIOD_NS;
  // Enable glitch filter.
  localparam int EN_GLITCH_NS = 5000;
  localparam int EN_GLITCH_CYC = EN_GLITCH_NS / CLK_PERIOD_NS;
  // Internal oscillator half period and soft-start ramp.
  localparam int SW_HALF_CYC = 50;
  localparam int SS_STEP_CYC = 16;
  localparam logic [7:0] GATE_FULL = 8'hff;
  localparam logic [7:0] GATE_ZERO = 8'h00;
  // Cycles without an external clock edge that count as a lost clock.
  localparam logic [7:0] EXT_TIMEOUT_CYC = 8'hc8;
  // Selectable current limit span, in mA.
  localparam logic [10:0] LIMIT_MIN_MA = 11'h064;
  localparam logic [10:0] LIMIT_MAX_MA = 11'h514;
  localparam logic [10:0] LIMIT_STEP_MA = 11'h064;
  localparam int PIN_COUNT = 11;

  typedef enum logic [1:0] {ST_OFF, ST_SOFT, ST_RUN, ST_DISCHARGE} dpmc_mode_t;

  typedef struct packed {
    logic supplyOk;
    logic ovRise;
    logic ovFall;
    logic tempHot;
    logic tempCool;
    logic enLevel;
    logic limitTrip;
    logic hardDip;
    logic hardTrip;
    logic clkFloat;
    logic extClk;
  } dpmc_pins_t;

  typedef struct packed {
    dpmc_pins_t sync1;
    dpmc_pins_t sync2;
    dpmc_pins_t sync3;
    dpmc_pins_t pin;
    dpmc_mode_t mode;
    logic phase;
    logic [7:0] halfCnt;
    logic syncMode;
    logic extPrev;
    logic [7:0] extTimer;
    logic [5:0] ovpCnt;
    logic ovpHalt;
    logic thermHalt;
    logic enFilt;
    logic [9:0] enCnt;
    logic [7:0] gateLevel;
    logic [3:0] ssCnt;
    logic [3:0] hicCnt;
    logic [14:0] hardCnt;
    logic gateA;
    logic gateB;
    logic drvEn;
    logic [10:0] limitMa;
  } dpmc_state_t;
endpackage : dpmc_pkg
`default_nettype wire

// ===== hw/dpmc_core.sv
// Protection and mode control for a push-pull transformer driver.
// Assumes analog comparators feed the pins asynchronously and that the
// drain stage floats whenever driveEnable is low.
//
// Contract
// - Overvoltage stops switching after 550 ns.
// - Overvoltage halt holds until falling threshold.
// - Current limit off during soft-start.
// - Compare switch current against selected limit.
// - Dip depth splits soft from hard short.
// - Soft short: 100 ns off, then retry.
// - Both switches off during retry interval.
// - Hard short trips fast at fixed level.
// - Long hard short discharges, then restarts.
// - Switch only with enable and supply good.
// - Enable without supply keeps switch idle.
// - Enable input passes a 5 us filter.
// - Floating enable reads as shutdown.
// - Thermal cutoff stops switching with hysteresis.
// - Power-up or enable rise runs soft-start.
// - Run mode switches at a fixed frequency.
// - Disabled or low supply floats drains.
// - Sync mode divides external clock by two.
// - Sync mode never reverts without power cycle.
// - Sync mode disables duty and spreading.
// - Floating clock pin stops switching.
`timescale 1ns/10ps
`default_nettype none
module dpmc_core #(
  parameter int HARD_PERSIST = dpmc_pkg::HARD_PERSIST_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire dpmc_pkg::dpmc_pins_t pinsIn,
  input wire logic [3:0] limitCode,
  output logic gateA,
  output logic gateB,
  output logic driveEnable,
  output logic ocpEnable,
  output logic softStartDischarge,
  output logic [7:0] gateLevel,
  output logic [10:0] limitMa,
  output logic syncMode,
  output logic dutyEnable,
  output logic spreadEnable
);
  import dpmc_pkg::*;

  dpmc_state_t st;
  dpmc_state_t next_st;

  // Limit codes above the top of the span saturate at the highest limit.
  function automatic logic [10:0] limitOf(input logic [3:0] code);
    logic [10:0] ma;
    ma = LIMIT_MIN_MA + 11'(code) * LIMIT_STEP_MA;
    if (ma > LIMIT_MAX_MA)
    begin
      ma = LIMIT_MAX_MA;
    end
    return ma;
  endfunction : limitOf

  always_comb
  begin
    logic hardNow;
    logic fault;
    logic extEdge;
    logic stall;
    logic active;
    logic gateOn;
    hardNow = 1'b0;
    fault = 1'b0;
    extEdge = 1'b0;
    stall = 1'b0;
    active = 1'b0;
    gateOn = 1'b0;
    next_st = st;

    // A pin counts as changed only once the second and third stages agree.
    next_st.sync1 = pinsIn;
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;
    for (int i = 0; i < PIN_COUNT; i++)
    begin
      if (st.sync2[i] == st.sync3[i])
      begin
        next_st.pin[i] = st.sync3[i];
      end
    end

    // Overvoltage: the stop waits out the response delay, the halt waits for the low side.
    if (st.ovpHalt)
    begin
      next_st.ovpCnt = 6'h00;
      if (st.pin.ovFall)
      begin
        next_st.ovpHalt = 1'b0;
      end
    end
    else if (st.pin.ovRise)
    begin
      next_st.ovpCnt = st.ovpCnt + 6'h01;
      if (st.ovpCnt == 6'(OVP_DELAY_CYC - 1))
      begin
        next_st.ovpHalt = 1'b1;
      end
    end
    else
    begin
      next_st.ovpCnt = 6'h00;
    end

    // Separate hot and cool comparators give the hysteresis.
    if (st.pin.tempHot)
    begin
      next_st.thermHalt = 1'b1;
    end
    else if (st.pin.tempCool)
    begin
      next_st.thermHalt = 1'b0;
    end

    // The filtered enable resets low, so an undriven pin leaves the part shut down.
    if (st.pin.enLevel != st.enFilt)
    begin
      next_st.enCnt = st.enCnt + 10'h001;
      if (st.enCnt == 10'(EN_GLITCH_CYC - 1))
      begin
        next_st.enFilt = st.pin.enLevel;
        next_st.enCnt = 10'h000;
      end
    end
    else
    begin
      next_st.enCnt = 10'h000;
    end

    // Sync mode is entered on the first valid external edge and is never left.
    next_st.extPrev = st.pin.extClk;
    extEdge = st.pin.extClk && !st.extPrev && !st.pin.clkFloat;
    if (extEdge)
    begin
      next_st.syncMode = 1'b1;
      next_st.extTimer = 8'h00;
    end
    else if (st.extTimer != EXT_TIMEOUT_CYC)
    begin
      next_st.extTimer = st.extTimer + 8'h01;
    end
    stall = st.pin.clkFloat || (st.syncMode && st.extTimer == EXT_TIMEOUT_CYC);

    hardNow = st.pin.hardDip && st.pin.hardTrip;
    fault = st.ovpHalt || st.thermHalt || !st.pin.supplyOk || !st.enFilt || stall;

    case (st.mode)
      ST_OFF:
      begin
        next_st.gateLevel = GATE_ZERO;
        next_st.ssCnt = 4'h0;
        if (!fault)
        begin
          next_st.mode = ST_SOFT;
        end
      end
      ST_SOFT:
      begin
        next_st.ssCnt = st.ssCnt + 4'h1;
        if (st.ssCnt == 4'(SS_STEP_CYC - 1))
        begin
          next_st.gateLevel = st.gateLevel + 8'h01;
        end
        if (st.gateLevel == GATE_FULL)
        begin
          next_st.mode = ST_RUN;
        end
      end
      ST_RUN:
      begin
        next_st.gateLevel = GATE_FULL;
      end
      ST_DISCHARGE:
      begin
        next_st.gateLevel = GATE_ZERO;
        next_st.ssCnt = 4'h0;
        if (!hardNow)
        begin
          next_st.mode = ST_SOFT;
        end
      end
      default:
      begin
        next_st.mode = ST_OFF;
      end
    endcase

    // A hard short that outlives the persistence window restarts from an empty ramp.
    if (hardNow && (st.mode == ST_SOFT || st.mode == ST_RUN))
    begin
      next_st.hardCnt = st.hardCnt + 15'h0001;
      if (st.hardCnt >= 15'(HARD_PERSIST - 1))
      begin
        next_st.mode = ST_DISCHARGE;
        next_st.gateLevel = GATE_ZERO;
        next_st.hardCnt = 15'h0000;
      end
    end
    else
    begin
      next_st.hardCnt = 15'h0000;
    end

    if (fault)
    begin
      next_st.mode = ST_OFF;
      next_st.gateLevel = GATE_ZERO;
    end

    // Hiccup retries; the limit comparator is ignored until the ramp finishes.
    if (st.hicCnt != 4'h0)
    begin
      next_st.hicCnt = st.hicCnt - 4'h1;
    end
    else if (st.mode == ST_RUN && st.pin.limitTrip && !st.pin.hardDip)
    begin
      next_st.hicCnt = 4'(HICCUP_CYC);
    end

    // Phase comes from the internal divider or from each external rising edge.
    active = (st.mode == ST_SOFT || st.mode == ST_RUN);
    if (!active)
    begin
      next_st.halfCnt = 8'h00;
    end
    else if (st.syncMode)
    begin
      if (extEdge)
      begin
        next_st.phase = !st.phase;
      end
    end
    else if (st.halfCnt == 8'(SW_HALF_CYC - 1))
    begin
      next_st.halfCnt = 8'h00;
      next_st.phase = !st.phase;
    end
    else
    begin
      next_st.halfCnt = st.halfCnt + 8'h01;
    end

    // The gates drop in the same edge that a retry starts, and one edge after a fault or a hard short shows in the state.
    gateOn = active && !fault && !hardNow && next_st.hicCnt == 4'h0;
    next_st.gateA = gateOn && !next_st.phase;
    next_st.gateB = gateOn && next_st.phase;
    next_st.drvEn = active && !fault;
    next_st.limitMa = limitOf(limitCode);
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign gateA = st.gateA;
  assign gateB = st.gateB;
  assign driveEnable = st.drvEn;
  assign ocpEnable = (st.mode == ST_RUN);
  assign softStartDischarge = (st.mode == ST_DISCHARGE);
  assign gateLevel = st.gateLevel;
  assign limitMa = st.limitMa;
  assign syncMode = st.syncMode;
  // Duty control and spreading make no sense against a foreign clock.
  assign dutyEnable = !st.syncMode;
  assign spreadEnable = !st.syncMode;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence hiccupStart;
    st.mode == ST_RUN && st.pin.limitTrip && !st.pin.hardDip && st.hicCnt == 4'h0;
  endsequence

  sequence bothOff;
    !gateA && !gateB;
  endsequence

  AST_OVP_DELAY: assert property (
    st.pin.ovRise && !st.ovpHalt && st.ovpCnt == 6'(OVP_DELAY_CYC - 1)
    |=> st.ovpHalt ##1 bothOff)
    else $error("overvoltage stop late");
  AST_OVP_HOLD: assert property (
    st.ovpHalt && !st.pin.ovFall |=> st.ovpHalt && !driveEnable)
    else $error("overvoltage halt released early");
  AST_OCP_SOFT: assert property (
    st.mode == ST_SOFT && st.hicCnt == 4'h0 |=> st.hicCnt == 4'h0)
    else $error("limit acted during soft-start");
  AST_HICCUP: assert property (
    hiccupStart |=> bothOff [*8])
    else $error("retry off-time too short");
  AST_HICCUP_END: assert property (
    hiccupStart |=> st.hicCnt == 4'(HICCUP_CYC) ##10 st.hicCnt == 4'h0)
    else $error("retry off-time length wrong");
  AST_HARD_OFF: assert property (
    st.pin.hardDip && st.pin.hardTrip |=> bothOff)
    else $error("hard short not cut");
  AST_HARD_RESTART: assert property (
    softStartDischarge |-> gateLevel == GATE_ZERO && !gateA && !gateB)
    else $error("discharge with gate drive");
  AST_EN_GLITCH: assert property (
    $changed(st.enFilt) |-> $past(st.enCnt) == 10'(EN_GLITCH_CYC - 1))
    else $error("enable changed without filter");
  AST_THERM: assert property (
    st.pin.tempHot |=> st.thermHalt ##1 (bothOff and !driveEnable))
    else $error("thermal cutoff ignored");
  AST_DRAIN_FLOAT: assert property (
    !st.enFilt || !st.pin.supplyOk |=> !driveEnable)
    else $error("drains driven while disabled");
  AST_SYNC_STICKY: assert property (
    syncMode |=> syncMode)
    else $error("sync mode left");
  AST_GATE_EXCL: assert property (
    !(gateA && gateB))
    else $error("both gates on together");
  AST_FAULT_OFF: assert property (
    st.ovpHalt || st.thermHalt || !st.pin.supplyOk |=> bothOff)
    else $error("gates on during a fault");
  AST_CLK_FLOAT: assert property (
    st.pin.clkFloat |=> (bothOff and !driveEnable))
    else $error("switching with a floating clock pin");
  AST_OCP_RAMP: assert property (
    ocpEnable |-> gateLevel == GATE_FULL)
    else $error("limit armed before the ramp ended");
endmodule : dpmc_core
`default_nettype wire

// ===== tb/dpmc_sys.sv
// System-side model: drives the enable level and the external clock pin.
// Assumes the bench clock; the external clock is derived from it.
`timescale 1ns/10ps
`default_nettype none
module dpmc_sys #(
  parameter int HALF = 20
) (
  input wire logic mclk,
  input wire logic supplyOk,
  input wire logic enReq,
  input wire logic clkRun,
  input wire logic floatReq,
  output logic enLevel,
  output logic extClk,
  output logic clkFloat
);
  int cnt = 0;
  logic clkQ = 1'b0;
  assign enLevel = enReq;
  // The clock pin floats until the device has supply, then rests low.
  assign clkFloat = !supplyOk || floatReq;
  assign extClk = clkQ;
  always @(negedge mclk)
  begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    // A floating pin carries no edges, so the modelled level rests low.
    if (!(clkRun && supplyOk) || floatReq)
      clkQ <= 1'b0;
    else if (cnt == HALF - 1)
      clkQ <= !clkQ;
  end
endmodule : dpmc_sys
`default_nettype wire

// ===== tb/dpmc_core_test.sv
// Self-checking bench for the driver protection and mode control.
// Assumes the system model in dpmc_sys and a short hard-short persistence.
`timescale 1ns/10ps
`default_nettype none
module dpmc_core_test;
  import dpmc_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic supplyOk = 1'b0, ovRise = 1'b0, ovFall = 1'b1, tempHot = 1'b0, tempCool = 1'b1;
  logic limitTrip = 1'b0, hardDip = 1'b0, hardTrip = 1'b0, enReq = 1'b0, clkRun = 1'b0;
  logic floatReq = 1'b0;
  logic [3:0] limitCode = 4'h0;
  logic enLevel, extClk, clkFloat, gateA, gateB, driveEnable, ocpEnable, ssDis, syncMode;
  logic dutyEnable, spreadEnable;
  logic [7:0] gateLevel;
  logic [10:0] limitMa;
  logic [5:0] obs;
  dpmc_pins_t pinsIn;
  int n_fail = 0;
  int num_checks = 0;
  always #5 mclk = !mclk;
  assign pinsIn = {supplyOk, ovRise, ovFall, tempHot, tempCool, enLevel, limitTrip, hardDip,
    hardTrip, clkFloat, extClk};
  assign obs = {gateA, gateA | gateB, syncMode, ssDis, ocpEnable, driveEnable};
  dpmc_sys sys (.mclk(mclk), .supplyOk(supplyOk), .enReq(enReq), .clkRun(clkRun),
    .floatReq(floatReq), .enLevel(enLevel), .extClk(extClk), .clkFloat(clkFloat));
  dpmc_core #(.HARD_PERSIST(20)) uut (.mclk(mclk), .rst_n(rst_n), .pinsIn(pinsIn),
    .limitCode(limitCode), .gateA(gateA), .gateB(gateB), .driveEnable(driveEnable),
    .ocpEnable(ocpEnable), .softStartDischarge(ssDis), .gateLevel(gateLevel),
    .limitMa(limitMa), .syncMode(syncMode), .dutyEnable(dutyEnable),
    .spreadEnable(spreadEnable));

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Waits are bounded; running out of time ends the run.
  task automatic waitSig(input int k, input logic v, input int lim);
    for (int i = 0; i < lim && obs[k] !== v; i++)
      @(negedge mclk);
    chk($sformatf("obs%0d", k), 11'(v), 11'(obs[k]));
    if (obs[k] !== v)
      print_verdict();
  endtask : waitSig

  task automatic hold(input int k, input logic v, input int n);
    logic ok;
    ok = 1'b1;
    repeat (n)
    begin
      @(negedge mclk);
      if (obs[k] !== v)
        ok = 1'b0;
    end
    chk($sformatf("steady obs%0d", k), 11'h001, 11'(ok));
  endtask : hold

  task automatic measure(input int exp);
    int n;
    waitSig(5, 1'b0, 200);
    waitSig(5, 1'b1, 200);
    for (n = 0; n < 200 && gateA === 1'b1; n++)
      @(negedge mclk);
    chk("gateA width", 11'(exp), 11'(n));
  endtask : measure

  task automatic t_start();
    int codes[4] = '{0, 4, 12, 15};
    enReq = 1'b1;
    hold(0, 1'b0, 700);
    supplyOk = 1'b1;
    waitSig(0, 1'b1, 520);
    chk("ocpEnable", 11'h000, 11'(ocpEnable));
    foreach (codes[i])
    begin
      limitCode = 4'(codes[i]);
      repeat (2) @(negedge mclk);
      chk("limitMa", codes[i] > 12 ? 11'h514 : 11'(100 + 100 * codes[i]), limitMa);
    end
    measure(SW_HALF_CYC);
    limitTrip = 1'b1;
    hold(4, 1'b1, 20);
    limitTrip = 1'b0;
    waitSig(1, 1'b1, 4200);
    chk("gateLevel", 11'h0ff, 11'(gateLevel));
  endtask : t_start

  task automatic t_hiccup();
    limitTrip = 1'b1;
    repeat (2) @(negedge mclk);
    limitTrip = 1'b0;
    waitSig(4, 1'b0, 8);
    hold(4, 1'b0, 9);
    waitSig(4, 1'b1, 1);
    enReq = 1'b0;
    repeat (100) @(negedge mclk);
    enReq = 1'b1;
    hold(0, 1'b1, 600);
  endtask : t_hiccup

  task automatic t_faults();
    hardDip = 1'b1;
    hardTrip = 1'b1;
    waitSig(4, 1'b0, 8);
    waitSig(2, 1'b1, 40);
    chk("gateLevel", 11'h000, 11'(gateLevel));
    hardDip = 1'b0;
    hardTrip = 1'b0;
    waitSig(4, 1'b1, 12);
    ovRise = 1'b1;
    ovFall = 1'b0;
    hold(4, 1'b1, OVP_DELAY_CYC);
    waitSig(4, 1'b0, 8);
    ovRise = 1'b0;
    hold(4, 1'b0, 40);
    ovFall = 1'b1;
    waitSig(4, 1'b1, 20);
    tempHot = 1'b1;
    tempCool = 1'b0;
    waitSig(4, 1'b0, 8);
    tempHot = 1'b0;
    hold(4, 1'b0, 30);
    tempCool = 1'b1;
    waitSig(4, 1'b1, 12);
  endtask : t_faults

  task automatic t_sync();
    enReq = 1'b0;
    waitSig(0, 1'b0, 520);
    enReq = 1'b1;
    waitSig(0, 1'b1, 520);
    clkRun = 1'b1;
    waitSig(3, 1'b1, 60);
    chk("duty and spread", 11'h000, 11'({dutyEnable, spreadEnable}));
    measure(40);
    floatReq = 1'b1;
    waitSig(4, 1'b0, 8);
    floatReq = 1'b0;
    waitSig(4, 1'b1, 12);
    clkRun = 1'b0;
    waitSig(4, 1'b0, 230);
    hold(4, 1'b0, 100);
    chk("syncMode", 11'h001, 11'(syncMode));
    rst_n = 1'b0;
    @(negedge mclk);
    chk("power cycle modes", 11'h003, 11'({syncMode, dutyEnable, spreadEnable}));
    rst_n = 1'b1;
    waitSig(0, 1'b1, 520);
    measure(SW_HALF_CYC);
  endtask : t_sync

  initial
  begin
    repeat (3) @(negedge mclk);
    chk("reset outputs", 11'h003, 11'({driveEnable, dutyEnable, spreadEnable}));
    rst_n = 1'b1;
    t_start();
    t_hiccup();
    t_faults();
    t_sync();
    print_verdict();
  end
endmodule : dpmc_core_test
`default_nettype wire
